// >>> hdl/chp_consts.svh
// Constants of the display controller host command port
// Contract
// - Address strobe fall captures bus and select
// - Low three bits index; bit three requests execution
// - Selected when nibble is 2, select low
// - Unselected: bus floats, registers untouched
// - Index 0 command/status; 1-7 argument registers
// - Command: four type bits, four parameters
// - Direction 1 loads data registers
// - Auto-increment bit; pointer select bit
// - Move source/destination: 01 main, 10 second
// - Move stop: 01 buffer end, 10 never
// - Busy set at launch, cleared at completion
// - Last-column flags when pointer column is 39
// - Alarm when last column and incrementing
// - Sync status bit reads 0 while masked
// - Bits 3,1,0 zero; 4-6 cleared per command
// - Launch at data strobe end if requested
// - Busy without request: only status reads work
// - Busy with request: abort and relaunch
// - Commands except masks stall at row borders
// - Indirect moves byte between register 1, resource
// - Arguments and command loadable in any order
// - Mask set forces sync bit to 0; reset follows sync
`ifndef CHP_CONSTS_SVH
`define CHP_CONSTS_SVH
`define CHP_SELF_NIBBLE 4'h2
`define CHP_IDX_CMD 3'h0
`define CHP_IDX_DATA1 3'h1
`define CHP_IDX_SEC_Y 3'h4
`define CHP_IDX_SEC_X 3'h5
`define CHP_IDX_MAIN_Y 3'h6
`define CHP_IDX_MAIN_X 3'h7
`define CHP_ST_BUSY 7
`define CHP_ST_ALARM 6
`define CHP_ST_MAIN_LC 5
`define CHP_ST_SEC_LC 4
`define CHP_ST_SYNC 2
`define CHP_LAST_COL 6'h27
`define CHP_CMD_NOP 8'h91
`define CHP_CMD_MASK_SET 8'h99
`define CHP_CMD_MASK_CLR 8'h95
`define CHP_CMD_INY 8'hb0
`define CHP_TYPE_IND 4'h8
`define CHP_TYPE_BYTE 4'h3
`define CHP_TYPE_LONG_SEC 4'h2
`define CHP_TYPE_SHORT_SEC 4'h7
`define CHP_MV_MAIN_TO_SEC 2'h1
`define CHP_MV_SEC_TO_MAIN 2'h2
`define CHP_MV_STOP_END 2'h1
`define CHP_MV_NO_STOP 2'h2
`define CHP_CLK_NS 25
`define CHP_UNIT_NS 1000
`define CHP_UNIT_CYC ((`CHP_UNIT_NS + `CHP_CLK_NS - 1) / `CHP_CLK_NS)
`define CHP_U_SHORT 1
`define CHP_U_IND 2
`define CHP_U_ACCESS 4
`define CHP_U_WORD 4
`endif

// >>> hdl/chp_pkg.sv
// Types shared by the host command port
`default_nettype none
package chp_pkg;
   // Contents of the temporary address register
   typedef struct packed {
      logic latched_select_n;
      logic [3:0] nibble;
      logic exec_request_bit;
      logic [2:0] idx;
   } chp_addr_type;
   // Command engine states
   typedef enum logic [1:0] {
      CHP_IDLE = 2'b00,
      CHP_START = 2'b01,
      CHP_RUN = 2'b10
   } chp_state_type;
   // Memory write request toward the display memory
   typedef struct packed {
      logic we;
      logic [15:0] addr;
      logic [7:0] wdata;
   } chp_mem_type;
endpackage
`default_nettype wire

// >>> hdl/chp_host_port.sv
// Host command port of the display controller: bus decode, registers, command engine
`default_nettype none
`include "chp_consts.svh"
module chp_host_port
   import chp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [7:0] ad_in,
   output logic [7:0] ad_out,
   output logic ad_oe,
   input wire logic addr_latch_strobe,
   input wire logic data_strobe_in,
   input wire logic host_read,
   input wire logic chip_sel_n,
   input wire logic vsync_state,
   input wire logic row_border,
   input wire logic [7:0] mem_rdata,
   output logic mem_we,
   output logic [15:0] mem_addr,
   output logic [7:0] mem_wdata
);
   // ****************************************************
   // Bus phase tracking
   // ****************************************************
   logic as_q_r;
   logic ds_q_r;
   chp_addr_type adr_r;
   wire as_fall = as_q_r && !addr_latch_strobe;
   wire ds_trail = ds_q_r && !data_strobe_in;
   // Strobe history for edge detection
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         as_q_r <= 1'b0;
         ds_q_r <= 1'b0;
      end
      else
      begin
         as_q_r <= addr_latch_strobe;
         ds_q_r <= data_strobe_in;
      end
   end
   // Address and select held for the whole data phase
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         adr_r <= '0;
      else if (as_fall)
         adr_r <= {chip_sel_n, ad_in};
   end
   wire sel = (adr_r.nibble == `CHP_SELF_NIBBLE) && !adr_r.latched_select_n;
   wire exec_request_bit = adr_r.exec_request_bit;
   wire idx_cmd = (adr_r.idx == `CHP_IDX_CMD);

   // ****************************************************
   // Register file and engine state
   // ****************************************************
   chp_state_type st_r;
   logic [7:0] cmd_r;
   logic [7:0] arg_r [1:7];
   logic [7:0] res_r [0:7];
   logic [15:0] cnt_r;
   logic mask_r;
   logic alarm_r;
   logic main_lc_r;
   logic sec_lc_r;
   chp_mem_type mem_r;
   wire busy = (st_r != CHP_IDLE);
   // Launch regardless of index; busy access limits come from the decode below
   wire launch = ds_trail && sel && exec_request_bit;
   // Writes: command any time except busy without request; args only when idle
   wire wr_ok = ds_trail && sel && !host_read;
   wire cmd_wr = wr_ok && idx_cmd && (!busy || exec_request_bit);
   wire arg_wr = wr_ok && !idx_cmd && !busy;

   // ****************************************************
   // Command decode
   // ****************************************************
   wire [3:0] ctype = cmd_r[7:4];
   wire [3:0] cpar = cmd_r[3:0];
   wire is_mask = (cmd_r == `CHP_CMD_MASK_SET) || (cmd_r == `CHP_CMD_MASK_CLR);
   wire is_ind = (ctype == `CHP_TYPE_IND);
   wire is_iny = (cmd_r == `CHP_CMD_INY);
   wire is_move = (ctype[3:2] == 2'b11) && (ctype[1:0] != 2'b00);
   wire is_acc = !ctype[3] && (ctype != 4'h1);
   wire dir_in = cpar[3];
   wire inc_en = cpar[0];
   // Second pointer: its own long/short types, or the byte type with select set
   wire sec_sel = (ctype == `CHP_TYPE_LONG_SEC) || (ctype == `CHP_TYPE_SHORT_SEC)
      || ((ctype == `CHP_TYPE_BYTE) && cpar[2]);
   wire [1:0] mv_dir = cpar[3:2];
   wire [1:0] mv_stop = cpar[1:0];
   wire mv_valid = (mv_dir == `CHP_MV_MAIN_TO_SEC) || (mv_dir == `CHP_MV_SEC_TO_MAIN);
   wire [5:0] mx = arg_r[`CHP_IDX_MAIN_X][5:0];
   wire [5:0] sx = arg_r[`CHP_IDX_SEC_X][5:0];
   wire mx_last = (mx == `CHP_LAST_COL);
   wire sx_last = (sx == `CHP_LAST_COL);
   wire [5:0] mx_inc = mx_last ? 6'h00 : mx + 6'h01;
   wire [5:0] sx_inc = sx_last ? 6'h00 : sx + 6'h01;
   wire [7:0] my_inc = arg_r[`CHP_IDX_MAIN_Y] + 8'h01;
   // Byte type on the main pointer carries column overflow into the row
   wire byte_wrap = (ctype == `CHP_TYPE_BYTE) && !sec_sel && mx_last;
   wire [15:0] ptr_addr = sec_sel
      ? {arg_r[`CHP_IDX_SEC_Y], arg_r[`CHP_IDX_SEC_X]}
      : {arg_r[`CHP_IDX_MAIN_Y], arg_r[`CHP_IDX_MAIN_X]};
   wire [15:0] unit_cyc = 16'(`CHP_UNIT_CYC);
   wire [15:0] load_cnt = is_mask || (cmd_r == `CHP_CMD_NOP) ? 16'(`CHP_U_SHORT) * unit_cyc
      : is_ind || is_iny ? 16'(`CHP_U_IND) * unit_cyc
      : is_move ? 16'(`CHP_U_WORD) * unit_cyc
      : 16'(`CHP_U_ACCESS) * unit_cyc;
   // Row border stalls all but the mask commands
   wire stall = row_border && !is_mask;
   wire step = (st_r == CHP_RUN) && !stall && (cnt_r == 16'h0001);
   // A move keeps stepping until its stop condition, or never for no-stop
   wire mv_end = (mv_stop == `CHP_MV_STOP_END) && (mx_last || sx_last);
   wire mv_more = is_move && mv_valid && !mv_end
      && ((mv_stop == `CHP_MV_STOP_END) || (mv_stop == `CHP_MV_NO_STOP));

   // ****************************************************
   // Status and read path
   // ****************************************************
   logic [7:0] status_w;
   always_comb
   begin
      status_w = 8'h00;
      status_w[`CHP_ST_BUSY] = busy;
      status_w[`CHP_ST_ALARM] = alarm_r;
      status_w[`CHP_ST_MAIN_LC] = main_lc_r;
      status_w[`CHP_ST_SEC_LC] = sec_lc_r;
      status_w[`CHP_ST_SYNC] = vsync_state && !mask_r;
   end
   // Busy makes argument reads meaningless; they return zero
   wire [7:0] rd_data = idx_cmd ? status_w
      : busy ? 8'h00 : arg_r[adr_r.idx];
   wire rd_drive = data_strobe_in && sel && host_read;

   // Bus drivers, floating whenever unselected
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ad_oe <= 1'b0;
         ad_out <= 8'h00;
      end
      else
      begin
         ad_oe <= rd_drive;
         ad_out <= rd_data;
      end
   end

   // ****************************************************
   // Command register
   // ****************************************************
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         cmd_r <= 8'h00;
      else if (cmd_wr)
         cmd_r <= ad_in;
   end

   // ****************************************************
   // Engine sequencing
   // ****************************************************
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         st_r <= CHP_IDLE;
         cnt_r <= 16'h0000;
      end
      else if (launch)
         st_r <= CHP_START;
      else
      begin
         case (st_r)
            CHP_START:
            begin
               st_r <= CHP_RUN;
               cnt_r <= load_cnt;
            end
            CHP_RUN:
            begin
               if (step && mv_more)
                  cnt_r <= load_cnt;
               else if (step)
                  st_r <= CHP_IDLE;
               else if (!stall)
                  cnt_r <= cnt_r - 16'h0001;
            end
            default:
               st_r <= CHP_IDLE;
         endcase
      end
   end

   // Status flags: cleared and evaluated at command start
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         alarm_r <= 1'b0;
         main_lc_r <= 1'b0;
         sec_lc_r <= 1'b0;
      end
      else if (st_r == CHP_START)
      begin
         main_lc_r <= is_acc && !sec_sel && mx_last;
         sec_lc_r <= is_acc && sec_sel && sx_last;
         alarm_r <= is_acc && inc_en && (sec_sel ? sx_last : mx_last);
      end
   end

   // Sync mask, changed only by the two mask commands
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         mask_r <= 1'b0;
      else if (step && is_mask)
         mask_r <= (cmd_r == `CHP_CMD_MASK_SET);
   end

   // ****************************************************
   // Argument and resource registers
   // ****************************************************
   // Host writes only while idle, engine only while busy, so one never hides the other
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         for (int i = 1; i < 8; i++)
            arg_r[i] <= 8'h00;
      end
      else if (arg_wr)
         arg_r[adr_r.idx] <= ad_in;
      else if (step)
      begin
         if (is_ind && dir_in)
            arg_r[`CHP_IDX_DATA1] <= res_r[cpar[2:0]];
         if (is_acc && dir_in)
            arg_r[`CHP_IDX_DATA1] <= mem_rdata;
         if (is_iny || ((is_acc || mv_more) && inc_en && byte_wrap)
            || (is_move && mv_stop == `CHP_MV_NO_STOP && mx_last))
            arg_r[`CHP_IDX_MAIN_Y] <= my_inc;
         if ((is_acc && inc_en && !sec_sel) || mv_more)
            arg_r[`CHP_IDX_MAIN_X] <= {2'b00, mx_inc};
         if ((is_acc && inc_en && sec_sel) || mv_more)
            arg_r[`CHP_IDX_SEC_X] <= {2'b00, sx_inc};
      end
   end

   // On-chip indirect resources
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < 8; i++)
            res_r[i] <= 8'h00;
      end
      else if (step && is_ind && !dir_in)
         res_r[cpar[2:0]] <= arg_r[`CHP_IDX_DATA1];
   end

   // ****************************************************
   // Display memory write request
   // ****************************************************
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         mem_r <= '0;
      else
      begin
         mem_r.we <= step && is_acc && !dir_in;
         if (step && is_acc)
         begin
            mem_r.addr <= ptr_addr;
            mem_r.wdata <= arg_r[`CHP_IDX_DATA1];
         end
      end
   end
   assign mem_we = mem_r.we;
   assign mem_addr = mem_r.addr;
   assign mem_wdata = mem_r.wdata;

   // ****************************************************
   // Assertions
   // ****************************************************
   sequence s_launch;
      ds_trail && sel && exec_request_bit;
   endsequence
   sequence s_start_run;
      (st_r == CHP_START) ##1 (st_r == CHP_RUN);
   endsequence

   a_launch_starts:
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_launch |=> s_start_run)
   else $error("Launch did not start the engine");

   a_busy_on_launch:
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_launch |=> status_w[`CHP_ST_BUSY] [*2])
   else $error("Busy not shown after launch");

   a_unsel_quiet:
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!sel && !busy) |=> $stable(cmd_r) && !ad_oe)
   else $error("Unselected access changed state");

   a_busy_cmd_hold:
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      (busy && !exec_request_bit) |=> $stable(cmd_r))
   else $error("Command changed while busy without request");

   a_zero_bits:
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      status_w[3] == 1'b0 && status_w[1:0] == 2'b00)
   else $error("Unused status bits not zero");

   a_sync_masked:
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      mask_r |-> status_w[`CHP_ST_SYNC] == 1'b0)
   else $error("Sync status visible while masked");

   a_stall_hold:
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      (st_r == CHP_RUN && stall && !launch) |=> $stable(cnt_r) && busy)
   else $error("Command advanced at row border");

   a_alarm_cause:
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(alarm_r) |-> (main_lc_r || sec_lc_r) && $past(inc_en))
   else $error("Alarm without last column and increment");

   a_lc_column:
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      (st_r == CHP_START && is_acc && !sec_sel) |=> main_lc_r == $past(mx_last))
   else $error("Main last-column flag wrong");

   a_done_idle:
   assert property (@(posedge sys_clk) disable iff (sys_rst)
      (step && !mv_more && !launch) |=> !status_w[`CHP_ST_BUSY])
   else $error("Busy stayed after completion");
endmodule
`default_nettype wire

// >>> bench/chp_host_model.sv
// Host microprocessor model driving the multiplexed address/data bus
`default_nettype none
module chp_host_model
(
   input wire logic sys_clk,
   output logic [7:0] ad_in,
   output logic addr_latch_strobe,
   output logic data_strobe_in,
   output logic host_read,
   output logic chip_sel_n,
   input wire logic [7:0] ad_out,
   input wire logic ad_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus with strobes parked
   initial
   begin
      ad_in = 8'h00;
      addr_latch_strobe = 1'b1;
      data_strobe_in = 1'b0;
      host_read = 1'b0;
      chip_sel_n = 1'b1;
   end
   // One bus cycle: address phase, then a data strobe held three edges
   task automatic xfer(input logic [7:0] a, input logic csn, input logic rd,
      input logic [7:0] wd, output logic [7:0] q, output logic oe);
      @(posedge sys_clk);
      ad_in <= a; // Address with nibble and request bit
      chip_sel_n <= csn;
      addr_latch_strobe <= 1'b1;
      @(posedge sys_clk);
      addr_latch_strobe <= 1'b0; // Falling strobe captures the address
      @(posedge sys_clk);
      ad_in <= rd ? ~a : wd; // A read never leaves the address on the lines
      host_read <= rd;
      data_strobe_in <= 1'b1;
      repeat (3) @(posedge sys_clk);
      q = ad_out;
      oe = ad_oe;
      data_strobe_in <= 1'b0;
      @(posedge sys_clk);
      ad_in <= ~ad_in; // Released lines keep changing
   endtask
endmodule
`default_nettype wire

// >>> bench/test_chp_host_port.sv
// Self-checking bench of the host command port against a register model
`default_nettype none
`include "chp_consts.svh"
module test_chp_host_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, sys_rst, ad_oe, addr_latch_strobe, data_strobe_in, host_read;
   logic chip_sel_n, vsync_state, row_border, mem_we, oe;
   logic [7:0] ad_in, ad_out, mem_rdata, mem_wdata, q;
   logic [15:0] mem_addr;
   logic [15:0] wq [$];
   int fails = 0;
   int comparisons = 0;
   int seed;
   int regs [8];
   int res [8];
   // ****
   // Clock, design and host
   // ****
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   chp_host_port i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ad_in(ad_in), .ad_out(ad_out),
      .ad_oe(ad_oe), .addr_latch_strobe(addr_latch_strobe), .data_strobe_in(data_strobe_in),
      .host_read(host_read), .chip_sel_n(chip_sel_n), .vsync_state(vsync_state),
      .row_border(row_border), .mem_rdata(mem_rdata), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata));
   chp_host_model i_host (.sys_clk(sys_clk), .ad_in(ad_in), .ad_oe(ad_oe),
      .addr_latch_strobe(addr_latch_strobe), .data_strobe_in(data_strobe_in),
      .host_read(host_read), .chip_sel_n(chip_sel_n), .ad_out(ad_out));
   // ****
   // Tasks
   // ****
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic acc(input logic [2:0] i, input logic x, input logic rd, input logic [7:0] d);
      i_host.xfer({`CHP_SELF_NIBBLE, x, i}, 1'b0, rd, d, q, oe);
      if (rd)
         chk("drive", 16'h1, {15'h0, oe});
   endtask
   task automatic cmd(input logic [7:0] c);
      acc(3'h0, 1'b1, 1'b0, c);
   endtask
   task automatic rdc(input logic [2:0] i, input logic [7:0] e);
      acc(i, 1'b0, 1'b1, 8'h00);
      chk("arg", {8'h0, e}, {8'h0, q});
   endtask
   // Status compared only on bits with a known value
   task automatic st(input logic [7:0] e, input logic [7:0] m);
      acc(3'h0, 1'b0, 1'b1, 8'h00);
      chk("status", {8'h0, e & m}, {8'h0, q & m});
   endtask
   // Bounded poll: a hang shows as busy still set
   task automatic idle(input int lim);
      int n;
      n = 0;
      q = 8'h80;
      while (q[`CHP_ST_BUSY] !== 1'b0 && n < lim)
      begin
         acc(3'h0, 1'b0, 1'b1, 8'h00);
         n++;
      end
      chk("busy", 16'h0, {15'h0, q[`CHP_ST_BUSY]});
   endtask
   task automatic wrap_up();
      if (fails == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Each memory write must match one queued expectation
   always @(posedge sys_clk)
      if (mem_we === 1'b1)
      begin
         chk("maddr", (wq.size() > 0) ? wq.pop_front() : 16'hdead, mem_addr);
         chk("mdata", 16'(regs[1] & 8'hff), {8'h0, mem_wdata});
      end
   initial
   begin
      repeat (30000) @(posedge sys_clk);
      fails++;
      wrap_up();
   end
   // ****
   // Scenarios
   // ****
   initial
   begin
      seed = 32'h389e;
      sys_rst = 1'b1;
      vsync_state = 1'b1;
      row_border = 1'b0;
      mem_rdata = 8'h00;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      cmd(`CHP_CMD_NOP);
      st(8'h80, 8'h8b);
      idle(20);
      // Arguments, then foreign or deselected cycles that must change nothing
      for (int i = 1; i < 8; i++)
      begin
         regs[i] = $random(seed) & 8'hff;
         acc(i[2:0], 1'b0, 1'b0, regs[i][7:0]);
      end
      i_host.xfer(8'h32, 1'b0, 1'b0, 8'h5a, q, oe);
      i_host.xfer(8'h23, 1'b1, 1'b0, 8'h5a, q, oe);
      i_host.xfer(8'h38, 1'b0, 1'b0, `CHP_CMD_NOP, q, oe);
      st(8'h00, 8'h80);
      i_host.xfer(8'h21, 1'b1, 1'b1, 8'h00, q, oe);
      chk("float", 16'h0, {15'h0, oe});
      for (int i = 1; i < 8; i++)
         rdc(i[2:0], regs[i][7:0]);
      // Sync bit follows the input until masked
      for (int v = 0; v < 2; v++)
      begin
         vsync_state <= v[0];
         st({5'h0, v[0], 2'h0}, 8'h0f);
      end
      cmd(`CHP_CMD_MASK_SET);
      idle(20);
      st(8'h00, 8'h0f);
      cmd(`CHP_CMD_MASK_CLR);
      idle(20);
      st(8'h04, 8'h0f);
      // Command loaded first, pointer at column 39, launched by an argument write
      acc(3'h0, 1'b0, 1'b0, 8'h31);
      acc(3'h6, 1'b0, 1'b0, 8'h05);
      acc(3'h7, 1'b0, 1'b0, 8'h27);
      wq.push_back(16'h0527);
      regs[1] = $random(seed) & 8'hff;
      acc(3'h1, 1'b1, 1'b0, regs[1][7:0]);
      st(8'he0, 8'hfb);
      idle(60);
      rdc(3'h7, 8'h00);
      rdc(3'h6, 8'h06);
      acc(3'h7, 1'b0, 1'b0, 8'h27);
      wq.push_back(16'h0627);
      cmd(8'h30);
      st(8'ha0, 8'hfb);
      idle(60);
      rdc(3'h7, 8'h27);
      cmd(`CHP_CMD_NOP);
      st(8'h80, 8'hfb);
      idle(20);
      mem_rdata <= 8'($random(seed));
      cmd(8'h38);
      idle(60);
      rdc(3'h1, mem_rdata);
      regs[1] = mem_rdata;
      // Y increment, then a byte write on the second pointer at column 39
      cmd(`CHP_CMD_INY);
      idle(30);
      rdc(3'h6, 8'h07);
      acc(3'h4, 1'b0, 1'b0, 8'h12);
      acc(3'h5, 1'b0, 1'b0, 8'h27);
      wq.push_back(16'h1227);
      cmd(8'h35);
      st(8'hd0, 8'hfb);
      idle(60);
      rdc(3'h5, 8'h00);
      rdc(3'h4, 8'h12);
      // Byte access: plain accesses refused, a request aborts it
      cmd(8'h30);
      acc(3'h2, 1'b0, 1'b0, 8'hc3);
      rdc(3'h2, 8'h00);
      cmd(`CHP_CMD_NOP);
      idle(10);
      rdc(3'h2, regs[2][7:0]);
      // Row border stalls a command but not a mask command
      row_border <= 1'b1;
      cmd(`CHP_CMD_NOP);
      repeat (12) acc(3'h0, 1'b0, 1'b1, 8'h00);
      chk("stall", 16'h1, {15'h0, q[`CHP_ST_BUSY]});
      cmd(`CHP_CMD_MASK_CLR);
      idle(12);
      row_border <= 1'b0;
      // Indirect resources stored from register 1, then loaded back
      for (int r = 0; r < 3; r++)
      begin
         res[r] = $random(seed) & 8'hff;
         acc(3'h1, 1'b0, 1'b0, res[r][7:0]);
         cmd(8'h80 | r[7:0]);
         idle(30);
      end
      for (int r = 0; r < 3; r++)
      begin
         cmd(8'h88 | r[7:0]);
         idle(30);
         rdc(3'h1, res[r][7:0]);
      end
      chk("mleft", 16'h0, 16'(wq.size()));
      wrap_up();
   end
endmodule
`default_nettype wire
